//--- inc/external_interrupt_pkg.sv
// constants, types and register map of the external interrupt and vector block
// assumes one 10 MHz clock and a 32-bit AXI4-Lite register bus
package external_interrupt_pkg;

  // source table: request pins, pin-change groups, then the peripherals
  localparam int         NUM_PERIPH          = 15;
  localparam int         NUM_SOURCES         = 19;
  localparam int         NUM_PC_INPUTS       = 16;
  localparam logic [4:0] FIRST_SOURCE_NUMBER = 5'h02;
  localparam logic [4:0] GROUP_HIGH_NUMBER   = 5'h05;

  // program-memory vector addresses, two words apart
  localparam logic [15:0] RESET_VECTOR        = 16'h0000;
  localparam logic [15:0] PIN_A_VECTOR        = 16'h0002;
  localparam logic [15:0] GROUP_HIGH_VECTOR   = 16'h0008;
  localparam logic [15:0] FIRST_PERIPH_VECTOR = 16'h000A;
  localparam logic [15:0] LAST_PERIPH_VECTOR  = 16'h0026;
  localparam logic [15:0] VECTOR_STEP         = 16'h0002;

  // register byte offsets
  localparam logic [7:0] OFS_SENSE     = 8'h00;
  localparam logic [7:0] OFS_EXT_EN    = 8'h04;
  localparam logic [7:0] OFS_EXT_FLAGS = 8'h08;
  localparam logic [7:0] OFS_PC_EN     = 8'h0C;
  localparam logic [7:0] OFS_PC_FLAGS  = 8'h10;
  localparam logic [7:0] OFS_MASK_LOW  = 8'h14;
  localparam logic [7:0] OFS_MASK_HIGH = 8'h18;
  localparam logic [7:0] OFS_GLOBAL    = 8'h1C;
  localparam logic [7:0] OFS_STATUS    = 8'h20;

  // field positions and reset values
  localparam int         SENSE_A_LSB   = 0;
  localparam int         SENSE_B_LSB   = 2;
  localparam int         STATUS_REQ    = 5;
  localparam logic [3:0] SENSE_RESET   = 4'h0;
  localparam logic [7:0] MASK_RESET    = 8'h00;
  localparam logic [1:0] SYNC_PRIMED   = 2'h3;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    SENSE_LOW_LEVEL  = 2'b00,
    SENSE_ANY_CHANGE = 2'b01,
    SENSE_FALLING    = 2'b10,
    SENSE_RISING     = 2'b11
  } sense_mode_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] data;
    logic [3:0]  strb;
  } axi_wr_t;

endpackage

//--- rtl/external_interrupt_vectors.sv
// external request pins, pin-change groups, priority and vector dispatch
// assumes pins asynchronous to clock and a core that acks vector entry
//
// The address map and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ps

// What this block does
// RQ1: every reset cause starts the core at program address 0x0000.
// RQ2: request pins vector at 0x0002 and 0x0004, groups at 0x0006, 0x0008.
// RQ3: upper pin-change group is vector number 5 at address 0x0008.
// RQ4: peripheral vectors step two words from 0x000A up to 0x0026.
// RQ5: pin activity requests even when the pin is driven as output.
// RQ6: upper group fires on enabled bits 15..8, lower on bits 7..0.
// RQ7: only inputs set in the group mask contribute to its request.
// RQ8: pin changes are seen without the I/O clock and wake from any sleep.
// RQ9: each request pin triggers on falling edge, rising edge or low level.
// RQ10: enabled low-level mode requests continuously while the pin is low.
// RQ11: edges on request pins are recognised only while the I/O clock runs.
// RQ12: low levels on request pins are seen asynchronously to wake from sleep.
// RQ13: I/O clock stops in all sleep modes but idle, blocking edge detection.
// RQ14: a waking level must be held by the source until start-up ends.
// RQ15: a level gone before start-up ends wakes the part but raises no request.
// RQ16: sense code 00 low, 01 any change, 10 falling, 11 rising.
// RQ17: pin flag set by edge, cleared by entry or written one, zero in level.
// RQ18: edge modes sample the pin; pulses over one clock always register.
// RQ19: forward only if individually and globally enabled; lowest number wins. Peripheral requests here need the global enable only.
// RQ20: pin events pass two flip-flops before any flag or request.
module external_interrupt_vectors
  import external_interrupt_pkg::*;
(
  input  wire logic                    clock,
  input  wire logic                    sys_rst,
  input  wire logic [7:0]              awaddr,
  input  wire logic                    awvalid,
  output logic                         awready,
  input  wire logic [31:0]             wdata,
  input  wire logic [3:0]              wstrb,
  input  wire logic                    wvalid,
  output logic                         wready,
  output logic [1:0]                   bresp,
  output logic                         bvalid,
  input  wire logic                    bready,
  input  wire logic [7:0]              araddr,
  input  wire logic                    arvalid,
  output logic                         arready,
  output logic [31:0]                  rdata,
  output logic [1:0]                   rresp,
  output logic                         rvalid,
  input  wire logic                    rready,
  input  wire logic                    ext_request_pin_a,
  input  wire logic                    ext_request_pin_b,
  input  wire logic [NUM_PC_INPUTS-1:0] pin_change_inputs,
  input  wire logic                    deep_sleep,
  input  wire logic [NUM_PERIPH-1:0]   periph_requests,
  input  wire logic                    irq_ack,
  output logic [15:0]                  reset_vector,
  output logic                         irq_request,
  output logic [15:0]                  irq_vector,
  output logic [4:0]                   irq_number,
  output logic [NUM_PERIPH-1:0]        periph_ack,
  output logic                         wake_request
);

  logic [1:0]               ext_s1_reg, ext_s2_reg, ext_prev_reg;
  logic [NUM_PC_INPUTS-1:0] pc_s1_reg, pc_s2_reg, pc_prev_reg;
  logic [1:0]               prime_reg;
  logic [3:0]               sense_reg;
  logic [1:0]               ext_en_reg, pc_en_reg, ext_flag_reg, pc_flag_reg;
  logic [7:0]               mask_low_reg, mask_high_reg;
  logic                     global_reg;
  logic                     aw_hold_reg, w_hold_reg;
  axi_wr_t                  wr_reg;
  logic [1:0]               ext_flag_next, pc_flag_next, ext_set, ext_level;
  logic [NUM_PC_INPUTS-1:0] pc_change;
  logic [NUM_SOURCES-1:0]   pend, ack_hit;
  logic [4:0]               sel_next;
  logic                     found_next, wr_fire;
  logic [1:0]               ext_w1c, pc_w1c;
  logic [31:0]              rd_data;
  logic                     rd_ok;
  logic                     primed;

  // two stages before anything looks at a pin; outputs driven as pins are
  // sampled the same way, so software can raise a request by writing them
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ext_s1_reg   <= 2'h0;
      ext_s2_reg   <= 2'h0;
      ext_prev_reg <= 2'h0;
      pc_s1_reg    <= 16'h0000;
      pc_s2_reg    <= 16'h0000;
      pc_prev_reg  <= 16'h0000;
    end else begin
      ext_s1_reg   <= {ext_request_pin_b, ext_request_pin_a}; // [RQ20] [RQ5]
      ext_s2_reg   <= ext_s1_reg;
      ext_prev_reg <= ext_s2_reg;
      pc_s1_reg    <= pin_change_inputs;                      // [RQ20] [RQ5]
      pc_s2_reg    <= pc_s1_reg;
      pc_prev_reg  <= pc_s2_reg;
    end
  end

  // hides the false edge from reset zeros into the first real samples
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      prime_reg <= 2'h0;
    end else if (prime_reg != SYNC_PRIMED) begin
      prime_reg <= prime_reg + 2'h1;
    end
  end
  assign primed = (prime_reg == SYNC_PRIMED);

  // per-pin sense decode and edge detection
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_pin
      sense_mode_t mode;
      logic        rise, fall, hit;
      assign mode = sense_mode_t'(sense_reg[2*gi +: 2]);
      assign rise = ext_s2_reg[gi] & ~ext_prev_reg[gi];
      assign fall = ~ext_s2_reg[gi] & ext_prev_reg[gi];
      always_comb begin
        unique case (mode)                                     // [RQ16] [RQ9]
          SENSE_LOW_LEVEL:  hit = 1'b0;
          SENSE_ANY_CHANGE: hit = rise | fall;
          SENSE_FALLING:    hit = fall;                        // [RQ18]
          SENSE_RISING:     hit = rise;
        endcase
      end
      // no I/O clock in deep sleep, so edges are not seen there
      assign ext_set[gi]   = hit & primed & ~deep_sleep;      // [RQ11] [RQ13]
      assign ext_level[gi] = (mode == SENSE_LOW_LEVEL);
    end
  endgenerate

  assign pc_change = (pc_s2_reg ^ pc_prev_reg) & {mask_high_reg, mask_low_reg}; // [RQ7]

  assign wr_fire = aw_hold_reg & w_hold_reg & ~bvalid;
  assign ext_w1c = (wr_fire && wr_reg.addr == OFS_EXT_FLAGS && wr_reg.strb[0])
                   ? wr_reg.data[1:0] : 2'h0;
  assign pc_w1c  = (wr_fire && wr_reg.addr == OFS_PC_FLAGS && wr_reg.strb[0])
                   ? wr_reg.data[1:0] : 2'h0;

  // a new event wins over a clear arriving in the same cycle
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      if (ext_level[i]) begin
        ext_flag_next[i] = 1'b0;                               // [RQ17]
      end else begin
        ext_flag_next[i] = (ext_flag_reg[i] & ~ext_w1c[i] & ~ack_hit[i]) | ext_set[i];
      end
    end
    // pin-change flags keep working in deep sleep
    pc_flag_next[0] = (pc_flag_reg[0] & ~pc_w1c[0] & ~ack_hit[2])
                      | (primed & (|pc_change[7:0]));          // [RQ6] [RQ8]
    pc_flag_next[1] = (pc_flag_reg[1] & ~pc_w1c[1] & ~ack_hit[3])
                      | (primed & (|pc_change[15:8]));         // [RQ6]
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ext_flag_reg <= 2'h0;
      pc_flag_reg  <= 2'h0;
    end else begin
      ext_flag_reg <= ext_flag_next;
      pc_flag_reg  <= pc_flag_next;
    end
  end

  // level mode looks at the pin now; a level gone after wake-up asks nothing
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      pend[i] = ext_en_reg[i]                                  // [RQ10] [RQ15]
                & (ext_level[i] ? ~ext_s2_reg[i] : ext_flag_reg[i]);
    end
    pend[2] = pc_en_reg[0] & pc_flag_reg[0];
    pend[3] = pc_en_reg[1] & pc_flag_reg[1];
    pend[NUM_SOURCES-1:4] = periph_requests;
  end

  // scan down so the lowest number is left standing
  always_comb begin
    found_next = 1'b0;
    sel_next   = 5'h00;
    for (int i = NUM_SOURCES - 1; i >= 0; i--) begin
      if (pend[i]) begin
        found_next = 1'b1;                                     // [RQ19]
        sel_next   = 5'(i);
      end
    end
  end

  always_comb begin
    for (int i = 0; i < NUM_SOURCES; i++) begin
      ack_hit[i] = irq_ack & irq_request & (irq_number == 5'(i) + FIRST_SOURCE_NUMBER);
    end
  end

  // dropped at the edge that ends the ack cycle so one entry is never taken twice
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      irq_request  <= 1'b0;
      irq_number   <= FIRST_SOURCE_NUMBER;
      irq_vector   <= PIN_A_VECTOR;
      periph_ack   <= 15'h0000;
      wake_request <= 1'b0;
      reset_vector <= RESET_VECTOR;
    end else begin
      irq_request  <= global_reg & found_next & ~irq_ack;     // [RQ19]
      irq_number   <= sel_next + FIRST_SOURCE_NUMBER;
      irq_vector   <= PIN_A_VECTOR + {10'h000, sel_next, 1'b0}; // [RQ2] [RQ3] [RQ4]
      periph_ack   <= ack_hit[NUM_SOURCES-1:4];
      wake_request <= |pend;                                   // [RQ12] [RQ8]
      reset_vector <= RESET_VECTOR;                            // [RQ1]
    end
  end

  // control registers written by software
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      sense_reg     <= SENSE_RESET;
      ext_en_reg    <= 2'h0;
      pc_en_reg     <= 2'h0;
      mask_low_reg  <= MASK_RESET;
      mask_high_reg <= MASK_RESET;
      global_reg    <= 1'b0;
    end else begin
      if (irq_ack && irq_request) begin
        global_reg <= 1'b0;
      end
      if (wr_fire && wr_reg.strb[0]) begin
        unique case (wr_reg.addr)
          OFS_SENSE:     sense_reg     <= wr_reg.data[3:0];
          OFS_EXT_EN:    ext_en_reg    <= wr_reg.data[1:0];
          OFS_PC_EN:     pc_en_reg     <= wr_reg.data[1:0];
          OFS_MASK_LOW:  mask_low_reg  <= wr_reg.data[7:0];
          OFS_MASK_HIGH: mask_high_reg <= wr_reg.data[7:0];
          OFS_GLOBAL:    global_reg    <= wr_reg.data[0];
          default: ;
        endcase
      end
    end
  end

  // AXI4-Lite write path: address and data taken in either order
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg  <= 1'b0;
      awready     <= 1'b1;
      wready      <= 1'b1;
      bvalid      <= 1'b0;
      bresp       <= RESP_OKAY;
      wr_reg      <= '0;
    end else begin
      if (awvalid && awready) begin
        aw_hold_reg <= 1'b1;
        awready     <= 1'b0;
        wr_reg.addr <= awaddr;
      end
      if (wvalid && wready) begin
        w_hold_reg  <= 1'b1;
        wready      <= 1'b0;
        wr_reg.data <= wdata;
        wr_reg.strb <= wstrb;
      end
      if (wr_fire) begin
        aw_hold_reg <= 1'b0;
        w_hold_reg  <= 1'b0;
        bvalid      <= 1'b1;
        unique case (wr_reg.addr)
          OFS_SENSE, OFS_EXT_EN, OFS_EXT_FLAGS, OFS_PC_EN, OFS_PC_FLAGS,
          OFS_MASK_LOW, OFS_MASK_HIGH, OFS_GLOBAL, OFS_STATUS: bresp <= RESP_OKAY;
          default: bresp <= RESP_SLVERR;
        endcase
      end
      if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  always_comb begin
    rd_ok   = 1'b1;
    rd_data = 32'h0000_0000;
    unique case (araddr)
      OFS_SENSE:     rd_data[3:0] = sense_reg;
      OFS_EXT_EN:    rd_data[1:0] = ext_en_reg;
      OFS_EXT_FLAGS: rd_data[1:0] = ext_flag_reg;
      OFS_PC_EN:     rd_data[1:0] = pc_en_reg;
      OFS_PC_FLAGS:  rd_data[1:0] = pc_flag_reg;
      OFS_MASK_LOW:  rd_data[7:0] = mask_low_reg;
      OFS_MASK_HIGH: rd_data[7:0] = mask_high_reg;
      OFS_GLOBAL:    rd_data[0]   = global_reg;
      OFS_STATUS:    rd_data[5:0] = {irq_request, irq_number};
      default:       rd_ok        = 1'b0;
    endcase
  end

  // read path: one read at a time, answer one cycle after the address
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= RESP_OKAY;
    end else begin
      if (arvalid && arready) begin
        arready <= 1'b0;
        rvalid  <= 1'b1;
        rdata   <= rd_data;
        rresp   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
      if (rvalid && rready) begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  a_reset_vector_zero: assert property (@(posedge clock) disable iff (sys_rst) // [RQ1]
    reset_vector == RESET_VECTOR) else $error("reset vector not zero");

  a_vector_address_map: assert property (@(posedge clock) disable iff (sys_rst) // [RQ2]
    irq_request |-> irq_vector == {10'h000, irq_number, 1'b0} - VECTOR_STEP)
    else $error("vector address does not match vector number");

  a_group_high_vector: assert property (@(posedge clock) disable iff (sys_rst) // [RQ3]
    (irq_request && irq_number == GROUP_HIGH_NUMBER) |-> irq_vector == GROUP_HIGH_VECTOR)
    else $error("upper group vector misplaced");

  a_periph_vector_range: assert property (@(posedge clock) disable iff (sys_rst) // [RQ4]
    (irq_request && irq_number > GROUP_HIGH_NUMBER) |->
      (irq_vector >= FIRST_PERIPH_VECTOR && irq_vector <= LAST_PERIPH_VECTOR))
    else $error("peripheral vector out of range");

  a_group_high_set: assert property (@(posedge clock) disable iff (sys_rst) // [RQ6]
    (primed && (|pc_change[15:8])) |=> pc_flag_reg[1])
    else $error("upper group change lost");

  a_group_mask_gate: assert property (@(posedge clock) disable iff (sys_rst) // [RQ7]
    (!pc_flag_reg[0] && ((pc_s2_reg[7:0] ^ pc_prev_reg[7:0]) & mask_low_reg) == 8'h00)
      |=> !pc_flag_reg[0])
    else $error("masked input set lower group flag");

  a_level_request_held: assert property (@(posedge clock) disable iff (sys_rst) // [RQ10]
    (global_reg && ext_en_reg[1] && sense_reg[3:2] == SENSE_LOW_LEVEL
      && !ext_s2_reg[1] && !irq_ack)
      |=> irq_request && irq_number <= FIRST_SOURCE_NUMBER + 5'h01)
    else $error("low level not requesting");

  a_edge_sleep_blocked: assert property (@(posedge clock) disable iff (sys_rst) // [RQ13]
    (deep_sleep && !ext_flag_reg[0]) |=> !ext_flag_reg[0])
    else $error("edge seen while I/O clock halted");

  a_falling_edge_set: assert property (@(posedge clock) disable iff (sys_rst) // [RQ18]
    (primed && !deep_sleep && sense_reg[1:0] == SENSE_FALLING
      && $fell(ext_s2_reg[0])) |=> ext_flag_reg[0])
    else $error("falling edge missed");

  a_level_flag_clear: assert property (@(posedge clock) disable iff (sys_rst) // [RQ17]
    (sense_reg[3:2] == SENSE_LOW_LEVEL) |=> !ext_flag_reg[1])
    else $error("flag set in level mode");

  a_request_needs_global: assert property (@(posedge clock) disable iff (sys_rst) // [RQ19]
    $rose(irq_request) |-> $past(global_reg) && !$past(irq_ack))
    else $error("request without global enable");

  a_lowest_number_wins: assert property (@(posedge clock) disable iff (sys_rst) // [RQ19]
    (global_reg && !irq_ack && pend[0] && pend[1]) |=> irq_number == FIRST_SOURCE_NUMBER)
    else $error("priority order wrong");

  a_two_stage_sync: assert property (@(posedge clock) disable iff (sys_rst) // [RQ20]
    ext_s2_reg == $past(ext_s1_reg) && pc_s2_reg == $past(pc_s1_reg))
    else $error("synchroniser stage skipped");

endmodule

//--- verif/core_entry_model.sv
// core-side model: takes vector entry after a programmable wait
// assumes irq_request is a level that drops the edge after irq_ack
`timescale 1ns/1ps
module core_entry_model (
  input  wire logic       clock,
  input  wire logic       sys_rst,
  input  wire logic       irq_request,
  input  wire logic [2:0] entry_delay,
  output logic            irq_ack
);
  logic [2:0] wait_reg;

  // one-cycle entry pulse, only while a request stands; slow when delay is large
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      irq_ack  <= 1'b0;
      wait_reg <= 3'h0;
    end else if (irq_ack || !irq_request) begin
      irq_ack  <= 1'b0;
      wait_reg <= 3'h0;
    end else if (wait_reg >= entry_delay) begin
      irq_ack <= 1'b1;
    end else begin
      wait_reg <= wait_reg + 3'h1;
    end
  end
endmodule

//--- verif/tb.sv
// self-checking bench for the external interrupt and vector block
// assumes the package constants and a core model answering vector entry
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((e) !== (g)) begin fails++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end
module tb;
  import external_interrupt_pkg::*;
  logic                  clock = 1'b0, sys_rst = 1'b1;
  logic [7:0]            awaddr = 8'h00, araddr = 8'h00;
  logic                  awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic                  arvalid = 1'b0, rready = 1'b0;
  logic [31:0]           wdata = 32'h0, rdata, mask;
  logic [3:0]            wstrb = 4'hF;
  logic                  awready, wready, bvalid, arready, rvalid;
  logic                  irq_ack, irq_request, wake_request;
  logic [1:0]            bresp, rresp;
  logic                  pin_a = 1'b1, pin_b = 1'b1, deep_sleep = 1'b0;
  logic [15:0]           pc_in = 16'h0000, reset_vector, irq_vector;
  logic [NUM_PERIPH-1:0] periph_req = '0, periph_ack, pa_exp;
  logic [4:0]            irq_number;
  logic [2:0]            entry_delay = 3'h0;
  int fails = 0, checks_done = 0, cycles = 0, entries = 0, en, u, j;
  int seed = 32'h3f51cb54;
  int exp_q[$];

  external_interrupt_vectors i_external_interrupt_vectors (
    .clock(clock), .sys_rst(sys_rst), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .ext_request_pin_a(pin_a), .ext_request_pin_b(pin_b), .pin_change_inputs(pc_in),
    .deep_sleep(deep_sleep), .periph_requests(periph_req), .irq_ack(irq_ack),
    .reset_vector(reset_vector), .irq_request(irq_request), .irq_vector(irq_vector),
    .irq_number(irq_number), .periph_ack(periph_ack), .wake_request(wake_request)
  );

  core_entry_model i_core_entry_model (
    .clock(clock), .sys_rst(sys_rst), .irq_request(irq_request),
    .entry_delay(entry_delay), .irq_ack(irq_ack)
  );

  initial begin
    forever #50 clock = ~clock;
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // each channel held until its own ready; response waited for without a bound
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clock);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge clock);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    `CHK("bresp", er, bresp)
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge clock);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge clock);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    `CHK("rdata", e, rdata)
    `CHK("rresp", er, rresp)
  endtask

  // global enable is cleared on every entry, so each expected entry re-arms it
  task automatic entry(input int num);
    int e0, n;
    e0 = entries;
    n = 0;
    exp_q.push_back(num);
    wr(OFS_GLOBAL, 32'h1, RESP_OKAY);
    while (entries == e0 && n < 200) begin
      @(posedge clock);
      n++;
    end
    `CHK("entry_seen", 1'b1, entries != e0)
  endtask

  // reference: vector word address and peripheral acknowledge from the number
  always @(posedge clock) begin
    if (!sys_rst && irq_ack === 1'b1) begin
      en = (exp_q.size() > 0) ? exp_q.pop_front() : 0;
      pa_exp = (en >= 6) ? NUM_PERIPH'(1 << (en - 6)) : '0;
      `CHK("irq_number", 5'(en), irq_number)
      `CHK("irq_vector", 16'(2 * (en - 1)), irq_vector)
      // ack pulse stands only until the next edge
      #1;
      `CHK("periph_ack", pa_exp, periph_ack)
      entries++;
    end
  end

  always @(posedge clock) begin
    cycles++;
    if (cycles == 8000) begin
      fails++;
      summarize();
    end
  end

  initial begin
    repeat (6) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clock);
    `CHK("reset_vector", 16'h0000, reset_vector)
    rd(OFS_STATUS, 32'h2, RESP_OKAY);
    rd(OFS_MASK_HIGH, 32'h0, RESP_OKAY);
    rd(8'h24, 32'h0, RESP_SLVERR);
    wr(8'h28, 32'h1, RESP_SLVERR);
    // change, falling, rising on pin b; flags cleared by a written one
    for (int m = 1; m < 4; m++) begin
      wr(OFS_SENSE, 32'(m << SENSE_B_LSB), RESP_OKAY);
      wr(OFS_EXT_FLAGS, 32'h3, RESP_OKAY);
      pin_b <= 1'b0;
      repeat (5) @(posedge clock);
      rd(OFS_EXT_FLAGS, 32'(m != 3) << 1, RESP_OKAY);
      wr(OFS_EXT_FLAGS, 32'h2, RESP_OKAY);
      pin_b <= 1'b1;
      repeat (5) @(posedge clock);
      rd(OFS_EXT_FLAGS, 32'(m != 2) << 1, RESP_OKAY);
    end
    pin_b <= 1'b0;
    repeat (5) @(posedge clock);
    wr(OFS_EXT_FLAGS, 32'h3, RESP_OKAY);
    deep_sleep <= 1'b1;
    pin_b <= 1'b1;
    repeat (5) @(posedge clock);
    rd(OFS_EXT_FLAGS, 32'h0, RESP_OKAY);
    deep_sleep <= 1'b0;
    // low level on pin b: no flag, request repeats while the level stays
    wr(OFS_SENSE, 32'h0, RESP_OKAY);
    pin_b <= 1'b0;
    wr(OFS_EXT_EN, 32'h2, RESP_OKAY);
    repeat (3) @(posedge clock);
    rd(OFS_EXT_FLAGS, 32'h0, RESP_OKAY);
    `CHK("wake_request", 1'b1, wake_request)
    `CHK("irq_idle", 1'b0, irq_request)
    entry(3);
    entry(3);
    wr(OFS_SENSE, 32'h2, RESP_OKAY);
    wr(OFS_EXT_EN, 32'h3, RESP_OKAY);
    pin_a <= 1'b0;
    periph_req <= NUM_PERIPH'(1);
    repeat (6) @(posedge clock);
    `CHK("irq_no_global", 1'b0, irq_request)
    entry(2);
    entry(3);
    pin_b <= 1'b1;
    entry(6);
    periph_req <= '0;
    pin_a <= 1'b1;
    wr(OFS_EXT_EN, 32'h0, RESP_OKAY);
    wr(OFS_PC_EN, 32'h3, RESP_OKAY);
    // a masked-out input stays silent, an enabled one raises its group
    for (int g = 0; g < 2; g++) begin
      u = $unsigned($random(seed)) % 8;
      j = (u + 1 + $unsigned($random(seed)) % 7) % 8;
      mask = 32'(($random(seed) & ~(1 << u) | (1 << j)) & 8'hFF);
      wr(OFS_MASK_LOW + 8'(4 * g), mask, RESP_OKAY);
      rd(OFS_MASK_LOW + 8'(4 * g), mask, RESP_OKAY);
      pc_in[8 * g + u] <= ~pc_in[8 * g + u];
      repeat (5) @(posedge clock);
      rd(OFS_PC_FLAGS, 32'h0, RESP_OKAY);
      pc_in[8 * g + j] <= ~pc_in[8 * g + j];
      repeat (5) @(posedge clock);
      rd(OFS_PC_FLAGS, 32'(1 << g), RESP_OKAY);
      entry(4 + g);
      rd(OFS_PC_FLAGS, 32'h0, RESP_OKAY);
    end
    // every peripheral source in turn, core answering promptly or slowly
    for (int k = 0; k < NUM_PERIPH; k++) begin
      entry_delay <= 3'($random(seed));
      periph_req <= NUM_PERIPH'(1 << k);
      entry(6 + k);
      periph_req <= '0;
      repeat (2) @(posedge clock);
    end
    summarize();
  end
endmodule
